// ==== src/bgr_pkg.sv ====
// Shared constants for the banked general register file.
// Assumes one core clock and an active-low asynchronous reset.
package bgr_pkg;
  // Data path and index widths
  localparam int BGR_DATA_W = 32;
  localparam int BGR_IDX_W = 4;
  localparam int BGR_PHYS_W = 5;
  localparam int BGR_NUM_PHYS = 24;
  // Physical layout: primary 0-7, shadow 8-15, unbanked 16-23
  localparam logic [4:0] BGR_PRIMARY_BASE = 5'h00;
  localparam logic [4:0] BGR_SHADOW_BASE = 5'h08;
  localparam logic [4:0] BGR_SHARED_BASE = 5'h10;
  // Bit positions inside the status word
  localparam int BGR_MODE_POS = 30;
  localparam int BGR_BANK_POS = 29;
  // Values forced by reset and by exception or interrupt entry
  localparam logic BGR_MODE_RST = 1'h1;
  localparam logic BGR_BANK_RST = 1'h1;
  localparam logic BGR_MODE_EXC = 1'h1;
  localparam logic BGR_BANK_EXC = 1'h1;
  // Read data value held before the first read
  localparam logic [31:0] BGR_RD_RST = 32'h0000_0000;
endpackage : bgr_pkg

// ==== src/bgr_store.sv ====
// Twenty-four word storage with one write and two registered reads.
// Assumes the caller only presents physical addresses 0 to 23.
`timescale 1ns/100ps
`default_nettype none
module bgr_store (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Write port
  input wire logic wr_en,
  input wire logic [bgr_pkg::BGR_PHYS_W-1:0] wr_addr,
  input wire logic [bgr_pkg::BGR_DATA_W-1:0] wr_data,
  // Read port A
  input wire logic rd_a_en,
  input wire logic [bgr_pkg::BGR_PHYS_W-1:0] rd_a_addr,
  output logic [bgr_pkg::BGR_DATA_W-1:0] rd_a_data,
  // Read port B
  input wire logic rd_b_en,
  input wire logic [bgr_pkg::BGR_PHYS_W-1:0] rd_b_addr,
  output logic [bgr_pkg::BGR_DATA_W-1:0] rd_b_data
);
  import bgr_pkg::*;

  // Whole state: the array and both read registers
  typedef struct packed {
    logic [BGR_NUM_PHYS-1:0][BGR_DATA_W-1:0] mem;
    logic [BGR_DATA_W-1:0] rd_a;
    logic [BGR_DATA_W-1:0] rd_b;
  } bgr_store_type;

  bgr_store_type st_ff; // Registered state
  bgr_store_type nxt_st; // Next state

  // Reads see the array before this cycle's write (read-before-write)
  always_comb begin
    nxt_st = st_ff;
    if (rd_a_en) begin
      nxt_st.rd_a = st_ff.mem[rd_a_addr];
    end
    if (rd_b_en) begin
      nxt_st.rd_b = st_ff.mem[rd_b_addr];
    end
    if (wr_en) begin
      nxt_st.mem[wr_addr] = wr_data;
    end
  end

  // Only the read registers see reset; the array is left as it was,
  // which avoids a wide reset tree on storage nobody may trust anyway
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.rd_a <= BGR_RD_RST;
      st_ff.rd_b <= BGR_RD_RST; // Array untouched
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_a_data = st_ff.rd_a;
  assign rd_b_data = st_ff.rd_b;
endmodule // bgr_store
`default_nettype wire

// ==== src/bgr_file.sv ====
// Banked general register file: mapping of logical names 0-15 onto
// 24 physical words, plus the mode and bank select state bits.
// Assumes the pipeline drives requests synchronous to core_clk.
// Notes on behaviour
// - Twenty-four 32-bit words: primary, shadow, unbanked
// - Exactly sixteen words visible under logical names
// - User mode: low names always hit primary
// - Privileged, bank select clear: primary bank
// - Privileged, bank select set: shadow bank
// - Privileged, bank select set: primary only via control moves
// - Exception entry maps low names to shadow
// - Reset leaves all register contents undefined
// - Reset and exceptions force bank select high
`timescale 1ns/100ps
`default_nettype none
module bgr_file (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Status word load and exception entry
  input wire logic status_wr_en,
  input wire logic [31:0] status_word,
  input wire logic exc_take,
  // Read port A
  input wire logic rd_a_en,
  input wire logic [bgr_pkg::BGR_IDX_W-1:0] rd_a_idx,
  input wire logic rd_a_alt,
  output logic rd_a_valid,
  output logic [bgr_pkg::BGR_DATA_W-1:0] rd_a_data,
  // Read port B
  input wire logic rd_b_en,
  input wire logic [bgr_pkg::BGR_IDX_W-1:0] rd_b_idx,
  input wire logic rd_b_alt,
  output logic rd_b_valid,
  output logic [bgr_pkg::BGR_DATA_W-1:0] rd_b_data,
  // Write port
  input wire logic wr_en,
  input wire logic [bgr_pkg::BGR_IDX_W-1:0] wr_idx,
  input wire logic wr_alt,
  input wire logic [bgr_pkg::BGR_DATA_W-1:0] wr_data,
  // Current mapping state and refusal flag
  output logic processor_mode_bit,
  output logic bank_select_bit,
  output logic alt_refused
);
  import bgr_pkg::*;

  // Whole control state of the mapper
  typedef struct packed {
    logic mode;
    logic bank;
    logic a_valid;
    logic b_valid;
    logic refused;
  } bgr_ctl_type;

  bgr_ctl_type st_ff; // Registered state
  bgr_ctl_type nxt_st; // Next state

  // Translate a logical name to a physical word address; sixteen
  // names always land on sixteen distinct words
  // In privileged mode alt selects the inactive bank, as the control moves do.
  function automatic logic [BGR_PHYS_W-1:0] bgr_map(
    input logic [BGR_IDX_W-1:0] idx,
    input logic alt,
    input logic mode,
    input logic bank
  );
    logic use_shadow;
    use_shadow = mode & (bank ^ alt);
    if (idx[3]) begin
      // High names ignore mode and bank entirely
      bgr_map = BGR_SHARED_BASE | {2'h0, idx[2:0]};
    end else if (use_shadow) begin
      bgr_map = BGR_SHADOW_BASE | {2'h0, idx[2:0]};
    end else begin
      bgr_map = BGR_PRIMARY_BASE | {2'h0, idx[2:0]};
    end
  endfunction

  // An alt access is only legal in privileged mode on names 0-7;
  // in user mode the shadow bank must stay out of reach
  function automatic logic bgr_bad_alt(
    input logic [BGR_IDX_W-1:0] idx,
    input logic alt,
    input logic mode
  );
    bgr_bad_alt = alt & (~mode | idx[3]);
  endfunction

  logic [BGR_PHYS_W-1:0] phys_a; // Mapped address, port A
  logic [BGR_PHYS_W-1:0] phys_b; // Mapped address, port B
  logic [BGR_PHYS_W-1:0] phys_w; // Mapped address, write port
  logic bad_a; // Port A alt access refused
  logic bad_b; // Port B alt access refused
  logic bad_w; // Write alt access refused
  logic go_a; // Read A reaches storage
  logic go_b; // Read B reaches storage
  logic go_w; // Write reaches storage

  // Address mapping uses the state as it stands this cycle;
  // a status load or exception takes effect from the next cycle
  always_comb begin
    phys_a = bgr_map(rd_a_idx, rd_a_alt, st_ff.mode, st_ff.bank);
    phys_b = bgr_map(rd_b_idx, rd_b_alt, st_ff.mode, st_ff.bank);
    phys_w = bgr_map(wr_idx, wr_alt, st_ff.mode, st_ff.bank);
    bad_a = rd_a_en & bgr_bad_alt(rd_a_idx, rd_a_alt, st_ff.mode);
    bad_b = rd_b_en & bgr_bad_alt(rd_b_idx, rd_b_alt, st_ff.mode);
    bad_w = wr_en & bgr_bad_alt(wr_idx, wr_alt, st_ff.mode);
    go_a = rd_a_en & ~bad_a;
    go_b = rd_b_en & ~bad_b;
    go_w = wr_en & ~bad_w; // Refused writes are dropped
  end

  // Next control state
  always_comb begin
    nxt_st = st_ff;
    // Every read answers next cycle, refused or not
    nxt_st.a_valid = rd_a_en;
    nxt_st.b_valid = rd_b_en;
    nxt_st.refused = bad_a | bad_b | bad_w;
    if (exc_take) begin
      // Entry wins over a status load in the same cycle, so the
      // interrupted code's primary bank is never the target
      nxt_st.mode = BGR_MODE_EXC;
      nxt_st.bank = BGR_BANK_EXC;
    end else if (status_wr_en) begin
      nxt_st.mode = status_word[BGR_MODE_POS];
      nxt_st.bank = status_word[BGR_BANK_POS];
    end
  end

  // Control registers; reset enters privileged mode, shadow bank
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.mode <= BGR_MODE_RST;
      st_ff.bank <= BGR_BANK_RST;
      st_ff.a_valid <= 1'h0;
      st_ff.b_valid <= 1'h0;
      st_ff.refused <= 1'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage; contents are not reset
  bgr_store bgr_store_i (
    .core_clk (core_clk),
    .rst_b (rst_b),
    .wr_en (go_w),
    .wr_addr (phys_w),
    .wr_data (wr_data),
    .rd_a_en (go_a),
    .rd_a_addr (phys_a),
    .rd_a_data (rd_a_data),
    .rd_b_en (go_b),
    .rd_b_addr (phys_b),
    .rd_b_data (rd_b_data)
  );

  // Outputs straight from registers
  assign rd_a_valid = st_ff.a_valid;
  assign rd_b_valid = st_ff.b_valid;
  assign processor_mode_bit = st_ff.mode;
  assign bank_select_bit = st_ff.bank;
  assign alt_refused = st_ff.refused;

  // Assertions

  // User mode never reaches shadow storage
  user_primary_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (go_a && !st_ff.mode && !rd_a_idx[3]) |-> phys_a < BGR_SHADOW_BASE)
    else $error("user mode read mapped off primary");

  // Privileged, bank clear, plain access hits primary
  priv_primary_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.mode && !st_ff.bank && !wr_alt && wr_en && !wr_idx[3])
    |-> phys_w == {2'h0, wr_idx[2:0]})
    else $error("bank clear write not on primary");

  // Privileged, bank set, plain access hits shadow
  priv_shadow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.mode && st_ff.bank && !rd_b_alt && !rd_b_idx[3])
    |-> phys_b == (BGR_SHADOW_BASE | {2'h0, rd_b_idx[2:0]}))
    else $error("bank set read not on shadow");

  // Privileged, bank set: primary reached only through alt access
  alt_primary_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (go_a && st_ff.bank && phys_a < BGR_SHADOW_BASE && st_ff.mode)
    |-> rd_a_alt)
    else $error("primary reached without control move");

  // High names are fixed to the unbanked set
  high_shared_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    rd_a_idx[3] |-> phys_a == {2'h2, rd_a_idx[2:0]})
    else $error("high name not on unbanked set");

  // Plain names map one to one onto sixteen words
  sixteen_map_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!rd_a_alt && !rd_b_alt && rd_a_idx != rd_b_idx) |-> phys_a != phys_b)
    else $error("two names share one word");

  // Exception entry switches low names to shadow next cycle
  exc_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_take |=> (st_ff.mode && st_ff.bank &&
    (rd_a_idx[3] || rd_a_alt || phys_a >= BGR_SHADOW_BASE)))
    else $error("exception did not select shadow bank");

  // Bank select high in the first cycle after reset release
  reset_bank_a: assert property (@(posedge core_clk)
    $rose(rst_b) |-> bank_select_bit && processor_mode_bit)
    else $error("bank select not high after reset");

  // Written word comes back on a read issued in the cycle after the write
  logic [BGR_PHYS_W-1:0] chk_addr_ff; // Helper: last write address
  logic [BGR_DATA_W-1:0] chk_data_ff; // Helper: last write data
  logic chk_wr_ff; // Helper: write happened last cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_wr_ff <= 1'h0;
      chk_addr_ff <= BGR_PRIMARY_BASE;
      chk_data_ff <= BGR_RD_RST;
    end else begin
      chk_wr_ff <= go_w;
      chk_addr_ff <= phys_w;
      chk_data_ff <= wr_data;
    end
  end
  store_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (chk_wr_ff && go_a && phys_a == chk_addr_ff && !go_w)
    |=> rd_a_valid && rd_a_data == $past(chk_data_ff))
    else $error("read did not return written word");
endmodule // bgr_file
`default_nettype wire

// ==== tb/bgr_pipe.sv ====
// Pipeline model: issues reads, writes, status loads and exceptions.
// Assumes the file answers a read at the taking edge itself.
`timescale 1ns/100ps
`default_nettype none
module bgr_pipe (
  // Clock
  input wire logic core_clk,
  // Status load and exception entry
  output logic status_wr_en,
  output logic [31:0] status_word,
  output logic exc_take,
  // Read ports
  output logic rd_a_en,
  output logic [3:0] rd_a_idx,
  output logic rd_a_alt,
  output logic rd_b_en,
  output logic [3:0] rd_b_idx,
  output logic rd_b_alt,
  // Write port
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic wr_alt,
  output logic [31:0] wr_data
);
  import bgr_pkg::*;
  // Quiet pipeline at time zero
  initial begin
    {status_wr_en, exc_take, rd_a_en, rd_b_en, wr_en} = 5'h00;
    {rd_a_alt, rd_b_alt, wr_alt, rd_a_idx, rd_b_idx, wr_idx} = 15'h0000;
    {status_word, wr_data} = 64'h0;
  end
  // One request cycle; data flips afterwards so stale values never match
  task automatic op(input logic w, input logic r, input logic [3:0] n,
                    input logic a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    {wr_en, rd_a_en, rd_b_en} = {w, r, r};
    {wr_idx, rd_a_idx, rd_b_idx} = {n, n, n};
    {wr_alt, rd_a_alt, rd_b_alt} = {a, a, a};
    wr_data = d;
    @(posedge core_clk);
    #1;
    {wr_en, rd_a_en, rd_b_en} = 3'h0;
    wr_data = ~d;
  endtask
  // Status load; with x set an exception lands in the same cycle,
  // so the entry must win over the loaded mode and bank
  task automatic st(input logic x, input logic m, input logic b);
    @(posedge core_clk);
    #1;
    {exc_take, status_wr_en} = {x, 1'b1};
    status_word = 32'h0000_0000;
    status_word[BGR_MODE_POS] = m;
    status_word[BGR_BANK_POS] = b;
    @(posedge core_clk);
    #1;
    {exc_take, status_wr_en} = 2'h0;
    status_word = ~status_word;
  endtask
  // Write name n while port B reads name m, then read n on port A at
  // the very next edge; the new word must already be in place
  task automatic wr_rd(input logic [3:0] n, input logic [3:0] m,
                       input logic [31:0] d);
    @(posedge core_clk);
    #1;
    {wr_en, rd_a_en, rd_b_en} = 3'h5;
    {wr_idx, rd_a_idx, rd_b_idx} = {n, n, m};
    {wr_alt, rd_a_alt, rd_b_alt} = 3'h0;
    wr_data = d;
    @(posedge core_clk);
    #1;
    {wr_en, rd_a_en, rd_b_en} = 3'h2;
    wr_data = ~d;
    @(posedge core_clk);
    #1;
    rd_a_en = 1'b0;
  endtask
endmodule // bgr_pipe
`default_nettype wire

// ==== tb/bgr_file_tb.sv ====
// Self-checking bench for the banked general register file.
// Assumes the pipeline model issues every request to the file.
`timescale 1ns/100ps
`default_nettype none
`define BGR_CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module banked_general_register_file_tb;
  import bgr_pkg::*;
  // Mapping case: mode, bank, alt, logical name, physical word hit
  typedef struct packed {
    logic prv; logic bk; logic alt; logic [3:0] idx; logic [4:0] ph;
  } bgr_row_type;
  logic core_clk, rst_b, status_wr_en, exc_take, wr_en, wr_alt;
  logic rd_a_en, rd_a_alt, rd_a_valid, rd_b_en, rd_b_alt, rd_b_valid;
  logic [3:0] rd_a_idx, rd_b_idx, wr_idx;
  logic [31:0] status_word, rd_a_data, rd_b_data, wr_data;
  logic processor_mode_bit, bank_select_bit, alt_refused;
  int fails = 0, compares = 0, cycles = 0, i;
  // Mapping table, one row per case
  bgr_row_type rows [0:8] = '{
    '{1'b0, 1'b1, 1'b0, 4'h3, 5'h03},
    '{1'b0, 1'b0, 1'b0, 4'h5, 5'h05},
    '{1'b1, 1'b0, 1'b0, 4'h2, 5'h02},
    '{1'b1, 1'b1, 1'b0, 4'h2, 5'h0A},
    '{1'b1, 1'b1, 1'b1, 4'h4, 5'h04},
    '{1'b1, 1'b0, 1'b1, 4'h7, 5'h0F},
    '{1'b0, 1'b1, 1'b0, 4'h9, 5'h11},
    '{1'b1, 1'b0, 1'b0, 4'h8, 5'h10},
    '{1'b1, 1'b1, 1'b0, 4'hF, 5'h17}};
  // Free-running core clock, 20 ns period
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  bgr_file bgr_file_i (.core_clk, .rst_b, .status_wr_en, .status_word,
    .exc_take, .rd_a_en, .rd_a_idx, .rd_a_alt, .rd_a_valid, .rd_a_data,
    .rd_b_en, .rd_b_idx, .rd_b_alt, .rd_b_valid, .rd_b_data, .wr_en,
    .wr_idx, .wr_alt, .wr_data, .processor_mode_bit, .bank_select_bit,
    .alt_refused);
  bgr_pipe bgr_pipe_i (.core_clk, .status_wr_en, .status_word, .exc_take,
    .rd_a_en, .rd_a_idx, .rd_a_alt, .rd_b_en, .rd_b_idx, .rd_b_alt,
    .wr_en, .wr_idx, .wr_alt, .wr_data);
  // Word pattern keyed by physical slot
  function automatic logic [31:0] pat(input int p);
    return 32'hA5C3_0000 + p;
  endfunction
  // Read one name on both ports; both answers must carry e
  task automatic rdchk(input logic [3:0] n, input logic a,
                       input logic [31:0] e);
    bgr_pipe_i.op(1'b0, 1'b1, n, a, 32'h0000_0000);
    `BGR_CHK("valid_a", 1'b1, rd_a_valid)
    `BGR_CHK("valid_b", 1'b1, rd_b_valid)
    `BGR_CHK("data_a", e, rd_a_data)
    `BGR_CHK("data_b", e, rd_b_data)
  endtask
  // Counts and verdict, the single exit of the run
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard; the whole run needs well under 400 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    rst_b = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    `BGR_CHK("mode", 1'b1, processor_mode_bit)
    `BGR_CHK("bank", 1'b1, bank_select_bit)
    `BGR_CHK("refused", 1'b0, alt_refused)
    `BGR_CHK("data_a", BGR_RD_RST, rd_a_data)
    `BGR_CHK("data_b", BGR_RD_RST, rd_b_data)
    // Fill all 24 words: plain names first, then shadow through alt
    bgr_pipe_i.st(1'b0, 1'b1, 1'b0);
    for (i = 0; i < 16; i++) begin
      bgr_pipe_i.op(1'b1, 1'b0, i[3:0], 1'b0, pat(i < 8 ? i : i + 8));
    end
    for (i = 0; i < 8; i++) begin
      bgr_pipe_i.op(1'b1, 1'b0, i[3:0], 1'b1, pat(i + 8));
    end
    foreach (rows[k]) begin
      bgr_pipe_i.st(1'b0, rows[k].prv, rows[k].bk);
      rdchk(rows[k].idx, rows[k].alt, pat(rows[k].ph));
    end
    // Valid is a single-cycle pulse
    @(posedge core_clk);
    #1;
    `BGR_CHK("valid_a", 1'b0, rd_a_valid)
    // Exception from user mode lands on the shadow bank
    bgr_pipe_i.st(1'b0, 1'b0, 1'b0);
    `BGR_CHK("mode", 1'b0, processor_mode_bit)
    bgr_pipe_i.st(1'b1, 1'b0, 1'b0);
    `BGR_CHK("mode", 1'b1, processor_mode_bit)
    `BGR_CHK("bank", 1'b1, bank_select_bit)
    rdchk(4'h1, 1'b0, pat(9));
    rdchk(4'h1, 1'b1, pat(1));
    // User-mode alt access: stale read data, write dropped
    bgr_pipe_i.st(1'b0, 1'b0, 1'b1);
    rdchk(4'h2, 1'b1, pat(1));
    `BGR_CHK("refused", 1'b1, alt_refused)
    bgr_pipe_i.op(1'b1, 1'b0, 4'h2, 1'b1, 32'h0BAD_0BAD);
    `BGR_CHK("refused", 1'b1, alt_refused)
    bgr_pipe_i.st(1'b0, 1'b1, 1'b1);
    rdchk(4'h9, 1'b1, pat(1));
    `BGR_CHK("refused", 1'b1, alt_refused)
    rdchk(4'h2, 1'b0, pat(10));
    // The refused user-mode write left primary word 2 alone
    rdchk(4'h2, 1'b1, pat(2));
    // Read and write of one name in one cycle gives the old word
    bgr_pipe_i.op(1'b1, 1'b1, 4'hC, 1'b0, 32'h1234_5678);
    `BGR_CHK("data_a", pat(20), rd_a_data)
    rdchk(4'hC, 1'b0, 32'h1234_5678);
    // Write then read at the next edge; port B reads another name
    bgr_pipe_i.wr_rd(4'h3, 4'hD, 32'h5A5A_0003);
    `BGR_CHK("valid_a", 1'b1, rd_a_valid)
    `BGR_CHK("data_a", 32'h5A5A_0003, rd_a_data)
    `BGR_CHK("valid_b", 1'b0, rd_b_valid)
    `BGR_CHK("data_b", pat(21), rd_b_data)
    // Reset in mid-run forces privileged mode and bank select
    bgr_pipe_i.st(1'b0, 1'b0, 1'b0);
    rst_b = 1'b0;
    #1;
    `BGR_CHK("mode", 1'b1, processor_mode_bit)
    `BGR_CHK("bank", 1'b1, bank_select_bit)
    `BGR_CHK("data_a", BGR_RD_RST, rd_a_data)
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    // First edge after release: reset values still stand
    @(posedge core_clk);
    #1;
    `BGR_CHK("mode", 1'b1, processor_mode_bit)
    `BGR_CHK("bank", 1'b1, bank_select_bit)
    `BGR_CHK("valid_a", 1'b0, rd_a_valid)
    `BGR_CHK("refused", 1'b0, alt_refused)
    conclude();
  end
endmodule // banked_general_register_file_tb
`default_nettype wire
